// ==== hbs_pkg.sv ====
// package for the half-bridge gate sequencer: constants, types and register map
package hbs_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int MIN_DEAD_NS     = 160;
  // longest time: round down, at least one cycle
  localparam int MIN_DEAD_CYC    = (MIN_DEAD_NS / CLK_PERIOD_NS) < 1 ? 1 : (MIN_DEAD_NS / CLK_PERIOD_NS);
  localparam int NO_SLOPE_NS     = 690;
  // least time: round up
  localparam int NO_SLOPE_CYC    = (NO_SLOPE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_CNT_W      = 6;

  // analog current figures selected by the sequencer outputs
  localparam int OSC_SLOW_UA     = 30;
  localparam int CMR_DISCH_UA    = 1800;

  // frequency command scale
  localparam int FREQ_W          = 8;
  localparam int FREQ_FULL       = 255;
  localparam int FB_LIMIT_PCT    = 60;
  localparam int HFP_PCT         = 75;
  localparam logic [7:0] FB_LIMIT_CODE = 8'(FREQ_FULL * FB_LIMIT_PCT / 100);
  localparam logic [7:0] HFP_CODE      = 8'(FREQ_FULL * HFP_PCT / 100);

  // register map (byte addresses, low address bits decoded)
  localparam int ADDR_W          = 8;
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h0C;

  // ctrl fields and reset
  localparam int CTRL_RUN_BIT    = 0;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
  localparam logic [3:0]  IRQ_MASK_RESET = 4'h0;

  // status fields
  localparam int ST_BOOST_OK_BIT = 0;
  localparam int ST_RUN_OK_BIT   = 1;
  localparam int ST_HIGH_BIT     = 2;
  localparam int ST_LOW_BIT      = 3;
  localparam int ST_CAP_BIT      = 4;
  localparam int ST_HFP_BIT      = 5;
  localparam int ST_STATE_LSB    = 8;
  localparam int ST_FREQ_LSB     = 16;

  // interrupt event bits
  localparam int IRQ_W           = 4;
  localparam int EV_CAP_BIT      = 0;
  localparam int EV_FORCE_BIT    = 1;
  localparam int EV_UVP_BIT      = 2;
  localparam int EV_HFP_BIT      = 3;

  // htrans encoding
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // comparator and enable inputs from the analog side
  typedef struct packed {
    logic boost_above_start;
    logic boost_below_stop;
    logic hb_slope;
    logic osc_high;
    logic osc_low;
    logic enable;
    logic protect;
  } hbs_comp_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LOW  = 4'h2,
    ST_HIGH = 4'h4,
    ST_DEAD = 4'h8
  } hbs_state_t;

endpackage

// ==== hbs_sync.sv ====
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
module hbs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule // hbs_sync

// ==== hbs_gate_seq.sv ====
// half-bridge gate sequencer with ahb-lite register slave
`timescale 1ns/10ps
module hbs_gate_seq
  import hbs_pkg::*;
(
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  input  wire hbs_pkg::hbs_comp_t  comp_in,
  input  wire logic [7:0]          feedback_sense,
  input  wire logic [7:0]          softstart_code,
  output logic                     high_gate_out,
  output logic                     low_gate_out,
  output logic                     osc_slow_charge,
  output logic                     cap_fast_discharge,
  output logic [7:0]               freq_code,
  output logic                     hfp_timer_start,
  output logic                     irq
);

  import hbs_pkg::*;

  // comparator synchronisation
  hbs_comp_t comp_s;

  hbs_sync #(
    .WIDTH ($bits(hbs_comp_t))
  ) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .din   (comp_in),
    .dout  (comp_s)
  );

  // sequencer state
  hbs_state_t             state_q;
  hbs_state_t             state_d;
  logic                   next_high_q;
  logic                   boost_ok_q;
  logic                   osc_low_d1_q;
  logic [DEAD_CNT_W-1:0]  dead_cnt_q;
  logic                   slope_seen_q;
  logic                   slow_q;
  logic                   cap_q;
  logic                   high_q;
  logic                   low_q;
  logic [7:0]             freq_q;
  logic                   hfp_q;

  // register state
  logic [31:0]            ctrl_q;
  logic [IRQ_W-1:0]       irq_stat_q;
  logic [IRQ_W-1:0]       irq_mask_q;
  logic                   wr_ph_q;
  logic                   rd_ph_q;
  logic [ADDR_W-1:0]      addr_q;
  logic [31:0]            hrdata_q;

  // run permission and boost undervoltage hysteresis
  wire run_ok   = boost_ok_q & comp_s.enable & ~comp_s.protect & ctrl_q[CTRL_RUN_BIT];
  wire boost_set = comp_s.boost_above_start;
  wire boost_clr = comp_s.boost_below_stop & ~comp_s.boost_above_start;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      boost_ok_q <= 1'b0;
    else if (boost_set)
      boost_ok_q <= 1'b1;
    else if (boost_clr)
      boost_ok_q <= 1'b0;
  end

  // stroke end is the rising edge of the oscillator's lower-level flag
  wire stroke_end = comp_s.osc_low & ~osc_low_d1_q;
  wire in_dead    = (state_q == ST_DEAD);
  wire slope_now  = comp_s.hb_slope | slope_seen_q;
  wire dead_min   = (dead_cnt_q >= DEAD_CNT_W'(MIN_DEAD_CYC - 1));
  // slope slower than the charge phase, or none at all: force on at the oscillator top
  wire force_on   = in_dead & dead_min & ~slope_now & comp_s.osc_high;
  wire slope_on   = in_dead & dead_min & slope_now;
  wire switch_on  = slope_on | force_on;
  wire no_slope_to = in_dead & ~slope_now & (dead_cnt_q == DEAD_CNT_W'(NO_SLOPE_CYC - 1));

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (run_ok)
          state_d = ST_LOW;
      ST_LOW:
        if (!run_ok)
          state_d = ST_IDLE;
        else if (stroke_end)
          state_d = ST_DEAD;
      ST_HIGH:
        if (stroke_end)
          state_d = ST_DEAD;
      ST_DEAD:
        if (switch_on)
          state_d = next_high_q ? ST_HIGH : ST_LOW;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q      <= ST_IDLE;
      next_high_q  <= 1'b1;
      osc_low_d1_q <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      osc_low_d1_q <= comp_s.osc_low;
      if (state_q == ST_IDLE)
        next_high_q <= 1'b1;
      else if (stroke_end && state_q != ST_DEAD)
        next_high_q <= (state_q == ST_LOW);
    end
  end

  // gates follow the next state, so a single state code keeps them exclusive
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      high_q <= 1'b0;
      low_q  <= 1'b0;
    end
    else
    begin
      high_q <= (state_d == ST_HIGH);
      low_q  <= (state_d == ST_LOW) || (state_d == ST_IDLE);
    end
  end

  // dead-time counter, slope latch, slow charge and capacitive flag
  wire enter_dead = (state_d == ST_DEAD) && !in_dead;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dead_cnt_q   <= '0;
      slope_seen_q <= 1'b0;
    end
    else if (!in_dead)
    begin
      dead_cnt_q   <= '0;
      slope_seen_q <= 1'b0;
    end
    else
    begin
      if (dead_cnt_q != '1)
        dead_cnt_q <= dead_cnt_q + 1'b1;
      if (comp_s.hb_slope)
        slope_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slow_q <= 1'b0;
      cap_q  <= 1'b0;
    end
    else
    begin
      if (enter_dead)
        slow_q <= 1'b1;
      else if (!in_dead || slope_now || switch_on)
        slow_q <= 1'b0;
      if (no_slope_to)
        cap_q <= 1'b1;
      else if (!in_dead || slope_now || switch_on)
        cap_q <= 1'b0;
    end
  end

  // frequency command: feedback clamped, only soft-start may go higher
  wire [7:0] fb_clamped = (feedback_sense > FB_LIMIT_CODE) ? FB_LIMIT_CODE : feedback_sense;
  wire [7:0] freq_sel   = (softstart_code > fb_clamped) ? softstart_code : fb_clamped;
  wire       hfp_d      = (freq_sel > HFP_CODE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      freq_q <= '0;
      hfp_q  <= 1'b0;
    end
    else
    begin
      freq_q <= freq_sel;
      hfp_q  <= hfp_d;
    end
  end

  // interrupt events
  logic [IRQ_W-1:0] ev;
  always_comb
  begin
    ev               = '0;
    ev[EV_CAP_BIT]   = no_slope_to;
    ev[EV_FORCE_BIT] = force_on;
    ev[EV_UVP_BIT]   = boost_ok_q & boost_clr;
    ev[EV_HFP_BIT]   = hfp_d & ~hfp_q;
  end

  // ahb-lite slave: writes zero wait, reads one wait state
  wire take     = hsel & hready & htrans[1];
  wire [ADDR_W-1:0] a_ofs = addr_q;
  wire hit_ctrl = (a_ofs == OFS_CTRL);
  wire hit_stat = (a_ofs == OFS_STATUS);
  wire hit_isr  = (a_ofs == OFS_IRQ_STAT);
  wire hit_imr  = (a_ofs == OFS_IRQ_MASK);
  wire wr_ctrl  = wr_ph_q & hit_ctrl;
  wire wr_isr   = wr_ph_q & hit_isr;
  wire wr_imr   = wr_ph_q & hit_imr;

  logic [31:0] status_w;
  always_comb
  begin
    status_w                   = '0;
    status_w[ST_BOOST_OK_BIT]  = boost_ok_q;
    status_w[ST_RUN_OK_BIT]    = run_ok;
    status_w[ST_HIGH_BIT]      = high_q;
    status_w[ST_LOW_BIT]       = low_q;
    status_w[ST_CAP_BIT]       = cap_q;
    status_w[ST_HFP_BIT]       = hfp_q;
    status_w[ST_STATE_LSB +: 4] = state_q;
    status_w[ST_FREQ_LSB +: 8] = freq_q;
  end

  wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
                       hit_stat ? status_w :
                       hit_isr  ? {{(32-IRQ_W){1'b0}}, irq_stat_q} :
                       hit_imr  ? {{(32-IRQ_W){1'b0}}, irq_mask_q} : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      addr_q  <= '0;
    end
    else
    begin
      wr_ph_q <= take & hwrite;
      rd_ph_q <= take & ~hwrite;
      if (take)
        addr_q <= haddr[ADDR_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= '0;
    else if (rd_ph_q)
      hrdata_q <= rd_mux;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q     <= CTRL_RESET;
      irq_mask_q <= IRQ_MASK_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= hwdata & CTRL_RESET;
      if (wr_imr)
        irq_mask_q <= hwdata[IRQ_W-1:0];
    end
  end

  // set wins over a write-one clear in the same cycle
  wire [IRQ_W-1:0] w1c = wr_isr ? hwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~w1c) | ev;
  end

  assign hreadyout          = ~rd_ph_q;
  assign hrdata             = hrdata_q;
  assign hresp              = 1'b0;
  assign high_gate_out      = high_q;
  assign low_gate_out       = low_q;
  assign osc_slow_charge    = slow_q;
  assign cap_fast_discharge = cap_q;
  assign freq_code          = freq_q;
  assign hfp_timer_start    = hfp_q;
  assign irq                = |(irq_stat_q & irq_mask_q);

endmodule // hbs_gate_seq

// ==== hbs_bridge_model.sv ====
// bridge switches, oscillator and slope comparators behind the gate sequencer
`timescale 1ns/10ps
module hbs_bridge_model (
  input  wire logic       hclk,
  input  wire logic       high_gate_out,
  input  wire logic       low_gate_out,
  input  wire logic [5:0] slope_dly,
  output logic            hb_slope,
  output logic            osc_low,
  output logic            osc_high
);
  logic [5:0] cnt_q = 6'h00;
  logic       on_q = 1'h0;
  wire        on_w = high_gate_out | low_gate_out;
  wire        off_w = !on_w && !on_q;
  always_ff @(posedge hclk)
  begin
    on_q <= on_w;
    if (on_w != on_q)
      cnt_q <= 6'h00;
    else if (on_w)
      cnt_q <= {1'h0, cnt_q[4:0] + 5'h01};
    else if (cnt_q != 6'h3F)
      cnt_q <= cnt_q + 6'h01;
  end
  // oscillator runs free while a gate conducts, so an idle low side still sees strokes end
  assign osc_low = on_w && on_q && (cnt_q[4:2] == 3'h7);
  // delay 3F means the node never moves; the comparator then idles low
  assign hb_slope = off_w && (cnt_q >= slope_dly) && (slope_dly != 6'h3F);
  assign osc_high = off_w && (cnt_q >= 6'h30);
endmodule // hbs_bridge_model

// ==== hbs_gate_seq_chk.sv ====
// assertions on the gate sequencer ports
`timescale 1ns/10ps
module hbs_gate_seq_chk
  import hbs_pkg::*;
(
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire hbs_pkg::hbs_comp_t comp_in,
  input wire logic [7:0]         feedback_sense,
  input wire logic [7:0]         softstart_code,
  input wire logic               high_gate_out,
  input wire logic               low_gate_out,
  input wire logic               osc_slow_charge,
  input wire logic               cap_fast_discharge,
  input wire logic [7:0]         freq_code,
  input wire logic               hfp_timer_start
);
  logic [7:0] off_q;
  logic       last_high_q;
  wire        on_w = high_gate_out | low_gate_out;
  wire        hit_w = comp_in.hb_slope | comp_in.osc_high;
  function automatic logic [7:0] fexp(logic [7:0] f, logic [7:0] s);
    f = (f > FB_LIMIT_CODE) ? FB_LIMIT_CODE : f;
    return (s > f) ? s : f;
  endfunction
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      off_q       <= 8'h00;
      last_high_q <= 1'h0;
    end
    else
    begin
      off_q       <= on_w ? 8'h00 : off_q + {7'h00, off_q != 8'hFF};
      last_high_q <= high_gate_out | (last_high_q & !low_gate_out);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_NO_OVERLAP: assert property (!(high_gate_out && low_gate_out))
    else $error("both gates on");
  AST_MIN_DEAD: assert property ($fell(high_gate_out) || $fell(low_gate_out) |-> !on_w [*6])
    else $error("dead time too short");
  AST_SLOW_CHARGE: assert property ($fell(high_gate_out) || $fell(low_gate_out) |-> osc_slow_charge)
    else $error("no slow charge after switch-off");
  AST_FREQ: assert property ($past(hresetn) |-> freq_code == fexp($past(feedback_sense), $past(softstart_code)))
    else $error("frequency command wrong");
  AST_HFP: assert property ($stable(freq_code) |-> hfp_timer_start == (freq_code > HFP_CODE))
    else $error("protection timer start wrong");
  AST_CAP_DELAY: assert property ($rose(cap_fast_discharge) |-> !on_w && off_q >= 8'h1A && off_q <= 8'h1E)
    else $error("capacitive flag at wrong time");
  AST_STROKE_END: assert property ($rose(comp_in.osc_low) && high_gate_out |-> ##[1:5] !high_gate_out)
    else $error("stroke did not end");
  AST_SWITCH_ON: assert property (hit_w && off_q > 8'h08 |-> ##[1:5] on_w)
    else $error("switch-on missing");
  AST_WAIT_SLOPE: assert property ($rose(on_w) && $past(hresetn) |-> $past(hit_w, 2))
    else $error("switch-on without slope");
  AST_ALTERNATE: assert property ($rose(high_gate_out) |-> !last_high_q)
    else $error("high side twice in a row");
  cover property ($rose(cap_fast_discharge));
  cover property (comp_in.osc_high && off_q > 8'h08);
  cover property ($rose(hfp_timer_start));
endmodule // hbs_gate_seq_chk
bind hbs_gate_seq hbs_gate_seq_chk u_chk (.hclk(hclk), .hresetn(hresetn), .comp_in(comp_in),
  .feedback_sense(feedback_sense), .softstart_code(softstart_code), .high_gate_out(high_gate_out),
  .low_gate_out(low_gate_out), .osc_slow_charge(osc_slow_charge), .cap_fast_discharge(cap_fast_discharge),
  .freq_code(freq_code), .hfp_timer_start(hfp_timer_start));

// ==== hbs_gate_seq_bench.sv ====
// self-checking bench for the half-bridge gate sequencer
`timescale 1ns/10ps
module hbs_gate_seq_bench;
  import hbs_pkg::*;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, rdy_s;
  logic [31:0] haddr = '0, hwdata = '0, rd, rd_s;
  logic [1:0]  htrans = '0;
  logic [7:0]  fb = '0, ss = '0;
  logic        bh = 1'h0, bl = 1'h0, en = 1'h1, prot = 1'h0;
  logic [5:0]  sd = 6'h02;
  int          error_cnt = 0, checks_done = 0, cyc = 0, hi_n = 0, n0;
  // feedback, soft-start, expected command, expected timer start
  logic [31:0] rows [5] = '{32'h4000_4000, 32'hC800_9900, 32'h64BF_BF00, 32'h00C0_C001, 32'hFFFF_FF01};
  wire         hready, hg, lg, slope, ol, oh, irq, high_freq_protection, hresp;
  wire [31:0]  hrdata;
  wire [7:0]   fq;
  hbs_comp_t   comp;
  assign comp = {bh, bl, slope, oh, ol, en, prot};
  hbs_gate_seq dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
    .hresp(hresp), .comp_in(comp), .feedback_sense(fb), .softstart_code(ss), .high_gate_out(hg),
    .low_gate_out(lg), .osc_slow_charge(), .cap_fast_discharge(), .freq_code(fq), .hfp_timer_start(high_freq_protection),
    .irq(irq));
  hbs_bridge_model u_br (.hclk(hclk), .high_gate_out(hg), .low_gate_out(lg), .slope_dly(sd),
    .hb_slope(slope), .osc_low(ol), .osc_high(oh));
  initial
  begin
    forever #12.5 hclk = ~hclk;
  end
  // bus answers are settled by mid-cycle and hold to the next edge
  always @(negedge hclk)
  begin
    rdy_s = hready;
    rd_s = hrdata;
  end
  always @(posedge hg) hi_n++;
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 9000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (rdy_s !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (rdy_s !== 1'h1);
    rd = rd_s;
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge hclk);
  endtask
  initial
  begin
    wt(10);
    hresetn <= 1'h1;
    bus(1'h0, OFS_CTRL, '0);
    cmp("ctrl", CTRL_RESET, rd);
    cmp("hresp", '0, hresp);
    bus(1'h0, OFS_IRQ_MASK, '0);
    cmp("irq mask", '0, rd);
    bus(1'h0, 8'h10, '0);
    cmp("unmapped", '0, rd);
    wt(100);
    cmp("gates", 32'h1, {hg, lg});
    cmp("strokes", '0, hi_n);
    foreach (rows[i])
    begin
      fb <= rows[i][31:24];
      ss <= rows[i][23:16];
      wt(4);
      cmp("freq", rows[i][15:8], fq);
      cmp("hfp", rows[i][0], high_freq_protection);
    end
    ss <= '0;
    $display("test reset and frequency done");
    bus(1'h1, OFS_IRQ_STAT, 32'hF);
    bus(1'h1, OFS_IRQ_MASK, 32'hF);
    bh <= 1'h1;
    wt(300);
    cmp("strokes", 32'h1, hi_n > 2);
    bus(1'h0, OFS_IRQ_STAT, '0);
    cmp("events", '0, rd);
    // node never moves: capacitive flag, then forced switch-on
    sd <= 6'h3F;
    n0 = hi_n;
    wt(300);
    cmp("forced strokes", 32'h1, hi_n > n0);
    bus(1'h0, OFS_IRQ_STAT, '0);
    cmp("events", 32'h3, rd);
    cmp("irq", 32'h1, irq);
    bus(1'h1, OFS_IRQ_MASK, '0);
    // the mask lands at the edge the task returns on; let it settle
    wt(1);
    cmp("masked irq", '0, irq);
    // late slope: capacitive flag but no forcing
    sd <= 6'h24;
    wt(10);
    bus(1'h1, OFS_IRQ_STAT, 32'hF);
    wt(300);
    bus(1'h0, OFS_IRQ_STAT, '0);
    cmp("events", 32'h1, rd);
    // fast slope first, so no late capacitive event slips in after the clear
    sd <= 6'h02;
    wt(10);
    bus(1'h1, OFS_IRQ_STAT, 32'hF);
    $display("test switching done");
    for (int k = 0; k < 3; k++)
    begin
      bh <= k != 0;
      bl <= k == 0;
      en <= k != 1;
      prot <= k == 2;
      wt(200);
      n0 = hi_n;
      wt(100);
      cmp("halted strokes", n0, hi_n);
      cmp("halted gates", 32'h1, {hg, lg});
      bh <= 1'h1;
      bl <= 1'h0;
      en <= 1'h1;
      prot <= 1'h0;
      wt(200);
      cmp("restart", 32'h1, hi_n > n0);
    end
    bus(1'h0, OFS_IRQ_STAT, '0);
    cmp("events", 32'h4, rd);
    $display("test halt done");
    finish_test();
  end
endmodule // hbs_gate_seq_bench
